// >>> core/adc_seq_pkg.sv
// constants and types shared by the converter control sequencer
// Behaviour
// - internal acquisition: track six ticks, then hold
// - external acquisition: second write with bit clear holds
// - control byte bit fields decoded as laid out
// - bipolar and range bits pick four ranges
// - unipolar straight binary, bipolar twos complement
// - power field: ext, int, standby, full
// - channel codes 000 to 101 select inputs 0-5
// - control byte captured from low eight lines
// - chip select high ignores strobes, bus released
// - shared bus driven only during selected read
// - conversions start only from selected host write
// - conversion takes exactly twelve ticks after hold
// - write during conversion aborts and reacquires
// - done flag low at end, high on read/write
// - repeated external select restarts open acquisition
// - reset: done high, normal, external clock
// - power-down waits for conversion end; write wakes
package adc_seq_pkg;
    // ==========================================================
    // control byte layout
    localparam int CTRL_W = 8;
    localparam int BIT_PWR_HI = 7;
    localparam int BIT_PWR_LO = 6;
    localparam int BIT_ACQ_EXT = 5;
    localparam int BIT_RANGE = 4;
    localparam int BIT_BIPOLAR = 3;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 3;
    localparam int CHAN_COUNT = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // power mode codes
    localparam logic [1:0] PWR_NORM_EXT = 2'h0;
    localparam logic [1:0] PWR_NORM_INT = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    localparam logic [1:0] PWR_FULL = 2'h3;

    // ==========================================================
    // data bus and conversion
    localparam int DATA_W = 12;
    localparam int ACQ_TICKS = 6;
    localparam int CONV_TICKS = 12;
    localparam logic [DATA_W-1:0] RESULT_RESET = 12'h000;

    // ==========================================================
    // timing: internal conversion clock derived from system clock
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int INT_CLK_HZ = 1_560_000;
    localparam int INT_DIV = SYS_CLK_HZ / INT_CLK_HZ;
    localparam int DIV_W = 8;

    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TRACK_INT = 4'b0010,
        ST_TRACK_EXT = 4'b0100,
        ST_CONVERT = 4'b1000
    } seq_state_type;

    // channel code to one-hot select, unused codes select nothing
    function automatic logic [CHAN_COUNT-1:0] chan_decode(
        input logic [CHAN_W-1:0] code);
        logic [CHAN_COUNT-1:0] sel;
        sel = '0;
        if (code < 3'h6) begin
            sel[code] = 1'b1;
        end
        return sel;
    endfunction
endpackage

// >>> core/sar_link_if.sv
// carrier between the sequencer and its tick and sar engines
`timescale 1ns/10ps
interface sar_link_if;
    import adc_seq_pkg::*;
    logic tick;
    logic int_clk_sel;
    logic start;
    logic abort;
    logic cmp;
    logic done;
    logic [DATA_W-1:0] trial;
    logic [DATA_W-1:0] code;

    modport ctrl (input tick, done, code, trial,
                  output int_clk_sel, start, abort, cmp);
    modport ticker (input int_clk_sel, output tick);
    modport engine (input tick, start, abort, cmp,
                    output done, trial, code);
endinterface // sar_link_if

// >>> core/conv_tick_gen.sv
// conversion clock tick: external pin edge or internal divider
`timescale 1ns/10ps
module conv_tick_gen
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // external conversion clock pin
    input wire logic conv_clk_i,
    // link to sequencer
    sar_link_if.ticker link
);
    import adc_seq_pkg::*;

    logic ext_q;
    logic [DIV_W-1:0] div_q;
    logic div_tick_q;
    logic ext_tick_q;

    // ==========================================================
    // external clock rising edge and internal divider
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ext_q <= 1'b0;
            div_q <= '0;
            div_tick_q <= 1'b0;
            ext_tick_q <= 1'b0;
        end else begin
            ext_q <= conv_clk_i;
            if (div_q == DIV_W'(INT_DIV - 1)) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 1'b1;
            end
            div_tick_q <= (div_q == DIV_W'(INT_DIV - 1));
            ext_tick_q <= conv_clk_i & ~ext_q;
        end
    end

    // select after the flops: a mode change never passes a stale tick
    assign link.tick = link.int_clk_sel ? div_tick_q : ext_tick_q;
endmodule // conv_tick_gen

// >>> core/sar_engine.sv
// twelve-tick successive approximation engine
`timescale 1ns/10ps
module sar_engine
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // link to sequencer
    sar_link_if.engine link
);
    import adc_seq_pkg::*;

    logic [DATA_W-1:0] trial_q;
    logic [DATA_W-1:0] bit_q;
    logic [DATA_W-1:0] code_q;
    logic busy_q;
    logic done_q;

    // ==========================================================
    // one bit decided per tick, msb first, so twelve ticks exactly
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trial_q <= '0;
            bit_q <= '0;
            code_q <= RESULT_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (link.abort) begin
                busy_q <= 1'b0;
            end else if (link.start) begin
                bit_q <= {1'b1, {(DATA_W-1){1'b0}}};
                trial_q <= {1'b1, {(DATA_W-1){1'b0}}};
                busy_q <= 1'b1;
            end else if (busy_q && link.tick) begin
                if (bit_q[0]) begin
                    code_q <= link.cmp ? trial_q : (trial_q & ~bit_q);
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    trial_q <= (link.cmp ? trial_q : (trial_q & ~bit_q))
                               | (bit_q >> 1);
                    bit_q <= bit_q >> 1;
                end
            end
        end
    end

    assign link.trial = trial_q;
    assign link.code = code_q;
    assign link.done = done_q;
endmodule // sar_engine

// >>> core/adc_host_control_sequencer.sv
// control byte port, acquisition and conversion sequencer
`timescale 1ns/10ps
module adc_host_control_sequencer
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host parallel port
    input wire logic chip_sel_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [adc_seq_pkg::DATA_W-1:0] data_i,
    output logic [adc_seq_pkg::DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    output logic done_flag_n_o,
    // external conversion clock
    input wire logic conv_clk_i,
    // analog front end
    input wire logic comparator_i,
    output logic [adc_seq_pkg::CHAN_COUNT-1:0] analog_in_0_to_5_o,
    output logic range_sel_o,
    output logic bipolar_sel_o,
    output logic track_hold_o,
    output logic [adc_seq_pkg::DATA_W-1:0] dac_code_o,
    // mode status
    output logic int_clk_sel_o,
    output logic standby_powerdown_o,
    output logic full_powerdown_o
);
    import adc_seq_pkg::*;

    sar_link_if link ();

    seq_state_type state_q;
    logic wr_n_q;
    logic rd_n_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [2:0] acq_cnt_q;
    logic int_clk_q;
    logic [1:0] pd_req_q;
    logic standby_q;
    logic full_pd_q;
    logic done_n_q;
    logic conv_bip_q;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] data_q;
    logic oe_n_q;
    logic hold_q;
    logic start_q;
    logic abort_q;
    logic [CHAN_COUNT-1:0] chan_q;
    logic [DATA_W-1:0] dac_q;

    logic sel;
    logic wr_rise;
    logic wr_fall;
    logic rd_fall;
    logic [CTRL_W-1:0] byte_in;
    logic [1:0] pwr_in;

    // ==========================================================
    // strobe edges, qualified by chip select
    assign sel = ~chip_sel_n_i;
    assign wr_rise = sel & write_strobe_n_i & ~wr_n_q;
    assign wr_fall = sel & ~write_strobe_n_i & wr_n_q;
    assign rd_fall = sel & ~read_strobe_n_i & rd_n_q;
    assign byte_in = data_i[CTRL_W-1:0];
    assign pwr_in = {byte_in[BIT_PWR_HI], byte_in[BIT_PWR_LO]};

    // strobe history; edges ignored while deselected
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else begin
            wr_n_q <= write_strobe_n_i | chip_sel_n_i;
            rd_n_q <= read_strobe_n_i | chip_sel_n_i;
        end
    end

    // ==========================================================
    // control byte register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_rise) begin
            ctrl_q <= byte_in;
        end
    end

    // ==========================================================
    // acquisition and conversion sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            acq_cnt_q <= '0;
            hold_q <= 1'b1;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            conv_bip_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            if (wr_rise) begin
                // any new byte abandons a running conversion
                abort_q <= state_q == ST_CONVERT;
                acq_cnt_q <= '0;
                if (byte_in[BIT_ACQ_EXT]) begin
                    state_q <= ST_TRACK_EXT;
                    hold_q <= 1'b0;
                end else if (state_q == ST_TRACK_EXT) begin
                    state_q <= ST_CONVERT;
                    hold_q <= 1'b1;
                    start_q <= 1'b1;
                    conv_bip_q <= byte_in[BIT_BIPOLAR];
                end else begin
                    state_q <= ST_TRACK_INT;
                    hold_q <= 1'b0;
                end
            end else begin
                case (state_q)
                    ST_TRACK_INT: begin
                        if (link.tick) begin
                            if (acq_cnt_q == 3'(ACQ_TICKS - 1)) begin
                                state_q <= ST_CONVERT;
                                hold_q <= 1'b1;
                                start_q <= 1'b1;
                                conv_bip_q <= ctrl_q[BIT_BIPOLAR];
                            end else begin
                                acq_cnt_q <= acq_cnt_q + 3'h1;
                            end
                        end
                    end
                    ST_CONVERT: begin
                        if (link.done) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_TRACK_EXT: begin
                        hold_q <= 1'b0; // open-ended until next write
                    end
                    default: begin
                        hold_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // clock mode and power-down
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            int_clk_q <= 1'b0;
            pd_req_q <= PWR_NORM_EXT;
            standby_q <= 1'b0;
            full_pd_q <= 1'b0;
        end else begin
            if (wr_rise) begin
                pd_req_q <= pwr_in;
                if (pwr_in == PWR_NORM_EXT) begin
                    int_clk_q <= 1'b0;
                end else if (pwr_in == PWR_NORM_INT) begin
                    int_clk_q <= 1'b1;
                end
            end
            if (wr_fall) begin
                // wake on the write falling edge, before the byte lands
                standby_q <= 1'b0;
                full_pd_q <= 1'b0;
                pd_req_q <= PWR_NORM_EXT;
            end else if (state_q == ST_IDLE && !wr_rise) begin
                // shut down only once no conversion is in flight
                standby_q <= pd_req_q == PWR_STANDBY;
                full_pd_q <= pd_req_q == PWR_FULL;
            end
        end
    end

    // ==========================================================
    // done flag and held result
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            done_n_q <= 1'b1;
            result_q <= RESULT_RESET;
        end else begin
            if (link.done && state_q == ST_CONVERT && !wr_rise) begin
                done_n_q <= 1'b0;
                // bipolar: offset binary to twos complement by msb flip
                result_q <= {link.code[DATA_W-1] ^ conv_bip_q,
                             link.code[DATA_W-2:0]};
            end else if (rd_fall || wr_rise) begin
                done_n_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // bus drive and front-end outputs
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            oe_n_q <= 1'b1;
            data_q <= RESULT_RESET;
            chan_q <= '0;
            dac_q <= '0;
        end else begin
            // released one clock after select or read goes away
            oe_n_q <= ~(sel & ~read_strobe_n_i);
            data_q <= result_q;
            chan_q <= chan_decode(ctrl_q[CHAN_LSB +: CHAN_W]);
            dac_q <= link.trial;
        end
    end

    assign link.int_clk_sel = int_clk_q;
    assign link.start = start_q;
    assign link.abort = abort_q | wr_rise;
    assign link.cmp = comparator_i;

    conv_tick_gen u_tick (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .conv_clk_i(conv_clk_i),
        .link(link.ticker)
    );

    sar_engine u_sar (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .link(link.engine)
    );

    assign data_o = data_q;
    assign data_oe_n_o = oe_n_q;
    assign done_flag_n_o = done_n_q;
    assign analog_in_0_to_5_o = chan_q;
    assign range_sel_o = ctrl_q[BIT_RANGE];
    assign bipolar_sel_o = ctrl_q[BIT_BIPOLAR];
    assign track_hold_o = hold_q;
    assign dac_code_o = dac_q;
    assign int_clk_sel_o = int_clk_q;
    assign standby_powerdown_o = standby_q;
    assign full_powerdown_o = full_pd_q;
endmodule // adc_host_control_sequencer

// >>> tb/analog_src_model.sv
// analog source and conversion clock seen by the converter
`timescale 1ns/10ps
module analog_src_model
    import adc_seq_pkg::*;
(
    // level under test and trial code
    input wire logic [adc_seq_pkg::DATA_W-1:0] level_i,
    input wire logic [adc_seq_pkg::DATA_W-1:0] dac_code_i,
    // answers to the converter
    output logic comparator_o,
    output logic conv_clk_o
);
    // ==========================================================
    // clock and comparator
    // free-running 2 MHz clock, the fastest the converter takes
    initial begin
        conv_clk_o = 1'b0;
    end
    always #250 conv_clk_o = ~conv_clk_o;

    // ideal comparator: input at or above the trial code
    assign comparator_o = (level_i >= dac_code_i);
endmodule // analog_src_model

// >>> tb/adc_seq_monitor.sv
// port-level assertions for the converter control sequencer
`timescale 1ns/10ps
module adc_seq_monitor
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host port
    input wire logic chip_sel_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [adc_seq_pkg::DATA_W-1:0] data_i,
    input wire logic [adc_seq_pkg::DATA_W-1:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic done_flag_n_o,
    // conversion side
    input wire logic conv_clk_i,
    input wire logic [adc_seq_pkg::CHAN_COUNT-1:0] analog_in_0_to_5_o,
    input wire logic track_hold_o,
    input wire logic int_clk_sel_o
);
    logic wr_lo_q, clk_q, th_q, int_acq_q, mode_q;
    logic [2:0] chan_q;
    logic [4:0] edges_q;
    logic wr_take;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================
    // helper logic
    assign wr_take = !chip_sel_n_i && write_strobe_n_i && wr_lo_q;

    // strobe history and the byte fields a write should apply
    always_ff @(posedge sys_clk_i) begin
        wr_lo_q <= rst_n_i && !chip_sel_n_i && !write_strobe_n_i;
        if (wr_take) begin
            chan_q <= data_i[2:0];
            mode_q <= data_i[BIT_PWR_HI] ? int_clk_sel_o : data_i[BIT_PWR_LO];
            int_acq_q <= !data_i[BIT_ACQ_EXT] && track_hold_o;
        end
    end

    // conversion clock edges since track_hold_o last moved
    always_ff @(posedge sys_clk_i) begin
        clk_q <= conv_clk_i;
        th_q <= track_hold_o;
        if (!rst_n_i || track_hold_o != th_q) begin
            edges_q <= 5'h00;
        end else if (conv_clk_i && !clk_q) begin
            edges_q <= edges_q + 5'h01;
        end
    end

    // ==========================================================
    // assertions
    a_bus_drive: assert property (
        data_oe_n_o == !$past(!chip_sel_n_i && !read_strobe_n_i))
        else $error("bus drive does not follow select and read");
    a_track_start: assert property (
        wr_take && (data_i[BIT_ACQ_EXT] || track_hold_o) |=> !track_hold_o)
        else $error("write did not start tracking");
    a_acq_six: assert property (
        $rose(track_hold_o) && int_acq_q && !int_clk_sel_o
        |-> edges_q == 5'h06)
        else $error("internal acquisition not six clocks");
    a_conv_twelve: assert property (
        $fell(done_flag_n_o) && !int_clk_sel_o
        |-> track_hold_o && edges_q == 5'h0c)
        else $error("conversion not twelve clocks");
    a_done_clear: assert property (
        !done_flag_n_o && !chip_sel_n_i && $fell(read_strobe_n_i)
        |-> ##[1:2] done_flag_n_o)
        else $error("done flag not cleared by read");
    a_result_hold: assert property (
        !done_flag_n_o && $past(!done_flag_n_o) && $past(!done_flag_n_o, 2)
        |-> $stable(data_o))
        else $error("result moved while ready");
    a_done_write: assert property (
        wr_take |=> done_flag_n_o)
        else $error("done flag not cleared by write");
    a_chan_route: assert property (
        wr_take && data_i[2:0] < 3'h6
        |-> ##2 analog_in_0_to_5_o == 6'(6'h01 << chan_q))
        else $error("channel select wrong");
    a_clk_mode: assert property (
        wr_take |-> ##2 int_clk_sel_o == mode_q)
        else $error("clock mode wrong after write");
endmodule // adc_seq_monitor

// >>> tb/test_adc_host_control_sequencer.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
module test_adc_host_control_sequencer;
    import adc_seq_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, chip_sel_n_i = 1'b1;
    logic write_strobe_n_i = 1'b1, read_strobe_n_i = 1'b1, oe_q = 1'b1;
    logic [DATA_W-1:0] data_i = 12'h000, level = 12'h000, data_o, dac_code_o;
    logic data_oe_n_o, done_flag_n_o, conv_clk_i, comparator_i;
    logic [CHAN_COUNT-1:0] analog_in_0_to_5_o;
    logic range_sel_o, bipolar_sel_o, track_hold_o, int_clk_sel_o;
    logic standby_powerdown_o, full_powerdown_o;
    logic [DATA_W-1:0] exp_q[$];
    logic [10:0] pwr_tab [4] = '{11'h440, 11'h580, 11'h6c0, 11'h000};
    logic [31:0] rnd = 32'hb3f7;
    int errors = 0, tests_run = 0;

    // ==========================================================
    // clock, design and far side
    always #5 sys_clk_i = ~sys_clk_i;
    adc_host_control_sequencer dut (.sys_clk_i, .rst_n_i, .chip_sel_n_i,
        .write_strobe_n_i, .read_strobe_n_i, .data_i, .data_o, .data_oe_n_o,
        .done_flag_n_o, .conv_clk_i, .comparator_i, .analog_in_0_to_5_o,
        .range_sel_o, .bipolar_sel_o, .track_hold_o, .dac_code_o,
        .int_clk_sel_o, .standby_powerdown_o, .full_powerdown_o);
    analog_src_model far (.level_i(level), .dac_code_i(dac_code_o),
        .comparator_o(comparator_i), .conv_clk_o(conv_clk_i));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [DATA_W-1:0] seen, want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask

    task automatic end_sim;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // write aligned just after a clock edge, so no edge races the write
    task automatic wr_byte(input logic [7:0] b, input logic [11:0] lv);
        @(posedge conv_clk_i);
        @(posedge sys_clk_i);
        level <= lv;
        chip_sel_n_i <= 1'b0;
        write_strobe_n_i <= 1'b0;
        data_i <= {4'h0, b};
        @(posedge sys_clk_i);
        write_strobe_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chip_sel_n_i <= 1'b1;
        data_i <= ~data_i;
    endtask

    task automatic wait_done;
        int n = 0;
        while (done_flag_n_o !== 1'b0 && n < 3000) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 3000) chk(12'(done_flag_n_o), 12'h0);
        repeat (2) @(posedge sys_clk_i);
    endtask

    // the watcher below compares what the read puts on the bus
    task automatic rd_res(input logic [DATA_W-1:0] want);
        exp_q.push_back(want);
        @(posedge sys_clk_i);
        chip_sel_n_i <= 1'b0;
        read_strobe_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chip_sel_n_i <= 1'b1;
        read_strobe_n_i <= 1'b1;
        @(negedge sys_clk_i);
        chk(12'(done_flag_n_o), 12'h1);
    endtask

    // compare each driven result with the oldest note
    always @(negedge sys_clk_i) begin
        if (data_oe_n_o === 1'b0 && oe_q && exp_q.size() > 0) begin
            chk(data_o, exp_q.pop_front());
        end
        oe_q = (data_oe_n_o !== 1'b0);
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        errors++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(negedge sys_clk_i);
        chk(12'({done_flag_n_o, int_clk_sel_o}), 12'h2);
        // strobes with chip select high must do nothing
        @(posedge sys_clk_i);
        write_strobe_n_i <= 1'b0;
        read_strobe_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        write_strobe_n_i <= 1'b1;
        read_strobe_n_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk(12'({track_hold_o, data_oe_n_o}), 12'h3);
        // each channel once, range and polarity cycled through all four, codes 0 to 5 only
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr_byte({3'h0, i[1], i[0], i[2:0]}, rnd[11:0]);
            wait_done();
            @(negedge sys_clk_i);
            chk(12'({range_sel_o, bipolar_sel_o}), 12'(i[1:0]));
            chk(12'(analog_in_0_to_5_o), 12'(6'h01 << i));
            rd_res({rnd[11] ^ i[0], rnd[10:0]});
        end
        // rewrite in mid-conversion: old result dropped
        wr_byte(8'h00, rnd[11:0]);
        repeat (650) @(posedge sys_clk_i);
        chk(12'({track_hold_o, done_flag_n_o}), 12'h3);
        rnd = lfsr(rnd);
        wr_byte(8'h01, rnd[11:0]);
        wait_done();
        rd_res(rnd[11:0]);
        // host-timed acquisition, restarted once, then held
        for (int k = 0; k < 2; k++) begin
            wr_byte(8'h22, rnd[11:0]);
            repeat (500) @(negedge sys_clk_i);
            chk(12'(track_hold_o), 12'h0);
        end
        wr_byte(8'h02, rnd[11:0]);
        repeat (2) @(negedge sys_clk_i);
        chk(12'(track_hold_o), 12'h1);
        wait_done();
        // a new byte while the result waits must raise the done flag
        wr_byte(8'h02, rnd[11:0]);
        @(negedge sys_clk_i);
        chk(12'(done_flag_n_o), 12'h1);
        wait_done();
        rd_res(rnd[11:0]);
        // internal clock, standby, full power-down, back to normal
        for (int j = 0; j < 4; j++) begin
            wr_byte(pwr_tab[j][7:0], rnd[11:0]);
            repeat (4) @(negedge sys_clk_i);
            chk(12'({standby_powerdown_o, full_powerdown_o}), 12'h0);
            wait_done();
            @(negedge sys_clk_i);
            chk(12'({int_clk_sel_o, full_powerdown_o, standby_powerdown_o}),
                12'(pwr_tab[j][10:8]));
            rd_res(rnd[11:0]);
        end
        end_sim();
    end
endmodule // test_adc_host_control_sequencer

bind adc_host_control_sequencer adc_seq_monitor mon (.sys_clk_i, .rst_n_i,
    .chip_sel_n_i, .write_strobe_n_i, .read_strobe_n_i, .data_i, .data_o,
    .data_oe_n_o, .done_flag_n_o, .conv_clk_i, .analog_in_0_to_5_o,
    .track_hold_o, .int_clk_sel_o);
